// ---- rtl/cts_pkg.sv ----
// Package of constants for the calibration trigger and low-power scheduler.
package cts_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] CTS_ADDR_SOFT_TRIG = 8'h6c;
  localparam logic [7:0] CTS_ADDR_LP_CTRL = 8'h6e;
  localparam logic [7:0] CTS_ADDR_VEC_EN = 8'h70;
  localparam logic [7:0] CTS_ADDR_VEC_PORT = 8'h71;

  localparam logic [7:0] CTS_RST_SOFT_TRIG = 8'h01;
  localparam logic [7:0] CTS_RST_LP_CTRL = 8'h88;
  localparam logic [7:0] CTS_RST_VEC_EN = 8'h00;
  localparam logic [7:0] CTS_RD_ZERO = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTS_SOFT_TRIG_BIT = 0;
  localparam int CTS_LOW_POWER_CAL_ENABLE_BIT = 0;
  localparam int CTS_SLEEP_UNTIL_TRIGGER_BIT = 1;
  localparam int CTS_WAKE_LO = 3;
  localparam int CTS_WAKE_HI = 4;
  localparam int CTS_SLEEP_LO = 5;
  localparam int CTS_SLEEP_HI = 7;
  localparam int CTS_VEC_EN_BIT = 0;

  // ****************************************
  // Scheduler and vector sizes
  // ****************************************
  localparam int CTS_NUM_CORES = 3;
  localparam int CTS_IDX_W = 2;
  localparam int CTS_CNT_W = 48;
  localparam int CTS_UNIT_CYCLES = 256;
  localparam int CTS_VEC_DEPTH = 673;
  localparam int CTS_VEC_AW = 10;

  typedef enum logic [1:0] {
    CTS_ST_IDLE,
    CTS_ST_SLEEP,
    CTS_ST_SETTLE,
    CTS_ST_CAL
  } cts_state_e;

  // Exponent of the sleep interval for each code.
  function automatic logic [5:0] cts_sleep_exp(input logic [2:0] code);
    logic [5:0] k;
    unique case (code)
      3'h0: k = 6'h03;
      3'h1: k = 6'h0f;
      3'h2: k = 6'h12;
      3'h3: k = 6'h15;
      3'h4: k = 6'h18;
      3'h5: k = 6'h1b;
      3'h6: k = 6'h1e;
      3'h7: k = 6'h21;
    endcase
    return k;
  endfunction : cts_sleep_exp

  // Exponent of the wake settling interval for each code.
  function automatic logic [5:0] cts_wake_exp(input logic [1:0] code);
    logic [5:0] k;
    unique case (code)
      2'h0: k = 6'h03;
      2'h1: k = 6'h12;
      2'h2: k = 6'h15;
      2'h3: k = 6'h18;
    endcase
    return k;
  endfunction : cts_wake_exp

endpackage : cts_pkg

// ---- rtl/cts_vec_mem.sv ----
// Calibration vector store with an auto-incrementing access pointer.
`timescale 1ns/1ps
module cts_vec_mem
  import cts_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Access port
  input wire logic enable,
  input wire logic rd_stb,
  input wire logic wr_stb,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  localparam logic [CTS_VEC_AW-1:0] LAST_IDX = CTS_VEC_AW'(CTS_VEC_DEPTH - 1);
  localparam logic [CTS_VEC_AW-1:0] ONE_IDX = CTS_VEC_AW'(1);

  logic [7:0] mem_ff [CTS_VEC_DEPTH];
  logic [CTS_VEC_AW-1:0] ptr_ff;
  logic [CTS_VEC_AW-1:0] nxt_ptr;
  logic [7:0] rdata_ff;
  wire logic access = enable & (rd_stb | wr_stb);

  // The pointer rewinds whenever the port is closed, so each opening starts a fresh pass.
  assign nxt_ptr = !enable ? '0 : !access ? ptr_ff : (ptr_ff == LAST_IDX) ? '0 : ptr_ff + ONE_IDX;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ptr_ff <= '0;
      rdata_ff <= '0;
    end
    else
    begin
      ptr_ff <= nxt_ptr;
      rdata_ff <= (enable & rd_stb) ? mem_ff[ptr_ff] : '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (enable & wr_stb)
    begin
      mem_ff[ptr_ff] <= wdata;
    end
  end

  assign rdata = rdata_ff;

endmodule : cts_vec_mem

// ---- rtl/cts_scheduler.sv ----
// Calibration trigger selection and low-power background calibration scheduler.
`timescale 1ns/1ps
module cts_scheduler
  import cts_pkg::*;
#(
  parameter int UNIT_CYCLES = CTS_UNIT_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Calibration configuration from neighbouring registers
  input wire logic hw_trigger_select,
  input wire logic background_cal_enable,
  // Trigger pin
  input wire logic cal_trigger_pin,
  // Calibration engine handshake
  input wire logic cal_done,
  output logic cal_req,
  output logic [CTS_IDX_W-1:0] cal_core,
  // Core power control
  output logic [CTS_NUM_CORES-1:0] core_sleep,
  // Status
  output logic cal_trigger,
  output logic vec_port_open
);

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0] soft_trig_ff;
  logic [7:0] lp_ctrl_ff;
  logic [7:0] vec_en_ff;
  logic [7:0] reg_rdata_ff;
  logic reg_rvalid_ff;
  logic port_rd_ff;
  logic [7:0] vec_rdata;

  wire logic sel_soft = reg_addr == CTS_ADDR_SOFT_TRIG;
  wire logic sel_lp = reg_addr == CTS_ADDR_LP_CTRL;
  wire logic sel_en = reg_addr == CTS_ADDR_VEC_EN;
  wire logic sel_port = reg_addr == CTS_ADDR_VEC_PORT;
  wire logic [7:0] rd_mux = sel_soft ? soft_trig_ff : sel_lp ? lp_ctrl_ff : sel_en ? vec_en_ff : CTS_RD_ZERO;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      soft_trig_ff <= CTS_RST_SOFT_TRIG;
      lp_ctrl_ff <= CTS_RST_LP_CTRL;
      vec_en_ff <= CTS_RST_VEC_EN;
      reg_rdata_ff <= CTS_RD_ZERO;
      reg_rvalid_ff <= 1'b0;
      port_rd_ff <= 1'b0;
    end
    else
    begin
      if (reg_wr & sel_soft)
      begin
        soft_trig_ff <= reg_wdata;
      end
      if (reg_wr & sel_lp)
      begin
        lp_ctrl_ff <= reg_wdata;
      end
      if (reg_wr & sel_en)
      begin
        vec_en_ff <= reg_wdata;
      end
      reg_rdata_ff <= reg_rd ? rd_mux : CTS_RD_ZERO;
      reg_rvalid_ff <= reg_rd;
      port_rd_ff <= reg_rd & sel_port;
    end
  end

  // ****************************************
  // Calibration vector port
  // ****************************************
  wire logic vec_open = vec_en_ff[CTS_VEC_EN_BIT];

  // Sequencing of the 673 accesses and the halted condition are left to software.
  cts_vec_mem u_vec_mem
  (
    .clk(clk),
    .nrst(nrst),
    .enable(vec_open),
    .rd_stb(reg_rd & sel_port),
    .wr_stb(reg_wr & sel_port),
    .wdata(reg_wdata),
    .rdata(vec_rdata)
  );

  assign reg_rdata = port_rd_ff ? vec_rdata : reg_rdata_ff;
  assign reg_rvalid = reg_rvalid_ff;
  assign vec_port_open = vec_open;

  // ****************************************
  // Trigger selection
  // ****************************************
  wire logic trig_sel = hw_trigger_select ? cal_trigger_pin : soft_trig_ff[CTS_SOFT_TRIG_BIT];
  assign cal_trigger = trig_sel;

  // ****************************************
  // Interval lengths
  // ****************************************
  wire logic lp_active = lp_ctrl_ff[CTS_LOW_POWER_CAL_ENABLE_BIT] & background_cal_enable;
  wire logic trig_mode = lp_ctrl_ff[CTS_SLEEP_UNTIL_TRIGGER_BIT];
  wire logic [5:0] sleep_k = cts_sleep_exp(lp_ctrl_ff[CTS_SLEEP_HI:CTS_SLEEP_LO]);
  wire logic [5:0] wake_k = cts_wake_exp(lp_ctrl_ff[CTS_WAKE_HI:CTS_WAKE_LO]);
  localparam logic [CTS_CNT_W-1:0] ONE_CNT = CTS_CNT_W'(1);
  localparam logic [CTS_CNT_W-1:0] UNIT_CNT = CTS_CNT_W'(UNIT_CYCLES);
  wire logic [CTS_CNT_W-1:0] sleep_len = CTS_CNT_W'(((ONE_CNT << sleep_k) + ONE_CNT) * UNIT_CNT);
  wire logic [CTS_CNT_W-1:0] wake_len = CTS_CNT_W'(((ONE_CNT << wake_k) + ONE_CNT) * UNIT_CNT);

  // ****************************************
  // Core sequencer
  // ****************************************
  localparam logic [CTS_IDX_W-1:0] LAST_CORE = CTS_IDX_W'(CTS_NUM_CORES - 1);
  localparam logic [CTS_IDX_W-1:0] ONE_CORE = CTS_IDX_W'(1);

  cts_state_e state_ff;
  cts_state_e nxt_state;
  logic [CTS_CNT_W-1:0] cnt_ff;
  logic [CTS_CNT_W-1:0] nxt_cnt;
  logic [CTS_IDX_W-1:0] core_ff;
  logic [CTS_IDX_W-1:0] nxt_core;

  // The timed sleep ends on its count; trigger sleep ends when the trigger is low.
  wire logic sleep_over = trig_mode ? !trig_sel : (cnt_ff == sleep_len - ONE_CNT);
  wire logic settle_over = cnt_ff == wake_len - ONE_CNT;
  wire logic [CTS_IDX_W-1:0] next_core = (core_ff == LAST_CORE) ? '0 : core_ff + ONE_CORE;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + ONE_CNT;
    nxt_core = core_ff;
    if (!lp_active)
    begin
      nxt_state = CTS_ST_IDLE;
      nxt_cnt = '0;
      nxt_core = '0;
    end
    else
    begin
      unique case (state_ff)
        CTS_ST_IDLE:
        begin
          nxt_state = CTS_ST_SLEEP;
          nxt_cnt = '0;
        end
        CTS_ST_SLEEP:
        begin
          if (sleep_over)
          begin
            nxt_state = CTS_ST_SETTLE;
            nxt_cnt = '0;
          end
        end
        CTS_ST_SETTLE:
        begin
          if (settle_over)
          begin
            nxt_state = CTS_ST_CAL;
            nxt_cnt = '0;
          end
        end
        CTS_ST_CAL:
        begin
          nxt_cnt = '0;
          if (cal_done)
          begin
            nxt_state = CTS_ST_SLEEP;
            nxt_core = next_core;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_ff <= CTS_ST_IDLE;
      cnt_ff <= '0;
      core_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      core_ff <= nxt_core;
    end
  end

  assign cal_req = state_ff == CTS_ST_CAL;
  assign cal_core = core_ff;

  // Cores not in their turn stay asleep; the chosen one wakes from settle onward.
  genvar gi;
  generate
    for (gi = 0; gi < CTS_NUM_CORES; gi++)
    begin : g_core
      assign core_sleep[gi] = (state_ff != CTS_ST_IDLE) &
        ((core_ff != CTS_IDX_W'(gi)) | (state_ff == CTS_ST_SLEEP));
    end
  endgenerate

endmodule : cts_scheduler

// ---- test/cts_scheduler_checker.sv ----
// Port checker of the calibration trigger and low-power scheduler.
`timescale 1ns/1ps
module cts_scheduler_checker
  import cts_pkg::*;
#(
  parameter int UNIT_CYCLES = CTS_UNIT_CYCLES
)
(
  // Clock, reset and register port
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // Trigger and scheduler
  input wire logic hw_trigger_select,
  input wire logic background_cal_enable,
  input wire logic cal_trigger_pin,
  input wire logic cal_done,
  input wire logic cal_req,
  input wire logic [CTS_IDX_W-1:0] cal_core,
  input wire logic [CTS_NUM_CORES-1:0] core_sleep,
  input wire logic cal_trigger,
  input wire logic vec_port_open
);
  // ****************************************
  // Shadow of the low-power control register
  // ****************************************
  logic [7:0] lp_ff;
  wire all_sleep = &core_sleep;
  // Interval lengths are only checked with a unit of one, where code 0 gives nine cycles.
  wire fast = UNIT_CYCLES == 1 && lp_ff[0] && background_cal_enable;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      lp_ff <= 8'h88;
    else if (reg_wr && reg_addr == 8'h6e)
      lp_ff <= reg_wdata;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_trig_pin; hw_trigger_select |-> cal_trigger == cal_trigger_pin; endproperty
  property p_vec_closed; reg_rd && reg_addr == 8'h71 && !vec_port_open |=> reg_rvalid && reg_rdata == 8'h00; endproperty
  property p_vec_open; reg_wr && reg_addr == 8'h70 |=> {7'h00, vec_port_open} == ($past(reg_wdata) & 8'h01); endproperty
  property p_idle; !background_cal_enable |=> !cal_req && core_sleep == 3'h0; endproperty
  property p_lp_off; !lp_ff[0] |=> core_sleep == 3'h0; endproperty
  property p_focus; cal_req |-> core_sleep == ~(3'h1 << cal_core); endproperty
  property p_hold; cal_req && !cal_done && background_cal_enable && !reg_wr |=> cal_req; endproperty
  property p_next;
    cal_req && cal_done && fast && !reg_wr |=>
      !cal_req && cal_core == ($past(cal_core) == 2'h2 ? 2'h0 : $past(cal_core) + 2'h1);
  endproperty
  property p_settle;
    fast && lp_ff[4:3] == 2'h0 && $fell(all_sleep) && core_sleep != 3'h0 |-> !cal_req [*8] ##1 !cal_req ##1 cal_req;
  endproperty
  property p_sleep;
    fast && lp_ff[7:5] == 3'h0 && !lp_ff[1] && $rose(all_sleep) |-> all_sleep [*8] ##1 all_sleep ##1 !all_sleep;
  endproperty
  property p_wake; fast && lp_ff[1] && all_sleep && !cal_trigger |=> !all_sleep; endproperty
  property p_stay; fast && lp_ff[1] && cal_trigger && all_sleep && !reg_wr |=> all_sleep; endproperty
  a_trig_pin: assert property (p_trig_pin) else $error("trigger does not follow pin");
  a_vec_closed: assert property (p_vec_closed) else $error("closed vector port read not zero");
  a_vec_open: assert property (p_vec_open) else $error("vector port open flag wrong");
  a_idle: assert property (p_idle) else $error("scheduler active without background enable");
  a_lp_off: assert property (p_lp_off) else $error("cores asleep with low power off");
  a_focus: assert property (p_focus) else $error("wrong core awake while calibrating");
  a_hold: assert property (p_hold) else $error("calibration request dropped early");
  a_next: assert property (p_next) else $error("core turn did not advance");
  a_settle: assert property (p_settle) else $error("settle length wrong");
  a_sleep: assert property (p_sleep) else $error("timed sleep length wrong");
  a_wake: assert property (p_wake) else $error("low trigger did not wake core");
  a_stay: assert property (p_stay) else $error("core woke with trigger high");
  c_cal: cover property ($rose(cal_req));
  c_wake: cover property (lp_ff[1] && !cal_trigger && all_sleep);
  c_vec: cover property (reg_rd && reg_addr == 8'h71 && vec_port_open);
endmodule : cts_scheduler_checker

bind cts_scheduler cts_scheduler_checker #(.UNIT_CYCLES(UNIT_CYCLES)) chk_i (.clk(clk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .hw_trigger_select(hw_trigger_select), .background_cal_enable(background_cal_enable),
  .cal_trigger_pin(cal_trigger_pin), .cal_done(cal_done), .cal_req(cal_req), .cal_core(cal_core),
  .core_sleep(core_sleep), .cal_trigger(cal_trigger), .vec_port_open(vec_port_open));

// ---- test/test_cts_scheduler.sv ----
// Self-checking bench of the calibration trigger and low-power scheduler.
`timescale 1ns/1ps
module test_cts_scheduler
  import cts_pkg::*;
;
  // ****************************************
  // Stimulus, tasks and tests
  // ****************************************
  logic clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, cal_done = 1'b0;
  logic hw_trigger_select = 1'b0, background_cal_enable = 1'b0, cal_trigger_pin = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_rvalid, cal_req, cal_trigger, vec_port_open;
  logic [1:0] cal_core;
  logic [2:0] core_sleep;
  int failures = 0, comparisons = 0, n, r;
  wire [7:0] trig8 = {7'h00, cal_trigger};
  wire [7:0] sleep8 = {5'h00, core_sleep};
  // A unit of one keeps code 0 intervals at nine cycles so the run stays short.
  cts_scheduler #(.UNIT_CYCLES(1)) uut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .hw_trigger_select(hw_trigger_select), .background_cal_enable(background_cal_enable),
    .cal_trigger_pin(cal_trigger_pin), .cal_done(cal_done), .cal_req(cal_req), .cal_core(cal_core),
    .core_sleep(core_sleep), .cal_trigger(cal_trigger), .vec_port_open(vec_port_open));
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk) reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk) reg_rd <= 1'b0;
    #1 chk({7'h00, reg_rvalid}, 8'h01);
    chk(reg_rdata, e);
  endtask : rd
  // Looks one step after the edge so a request launched on that edge is never raced.
  task automatic wait_cal(input int cycles);
    n = 0;
    #1;
    while (cal_req !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({7'h00, cal_req}, 8'h01);
    chk(n[7:0], cycles[7:0]);
  endtask : wait_cal
  task test_done;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done
  initial
  begin
    #100000;
    failures++;
    test_done;
  end
  initial
  begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rd(CTS_ADDR_SOFT_TRIG, 8'h01);
    rd(CTS_ADDR_LP_CTRL, 8'h88);
    rd(CTS_ADDR_VEC_EN, 8'h00);
    rd(8'h6d, 8'h00);
    $display("test registers done");
    chk(trig8, 8'h01);
    wr(CTS_ADDR_SOFT_TRIG, 8'h00);
    @(posedge clk) cal_trigger_pin <= 1'b1;
    #1 chk(trig8, 8'h00);
    @(posedge clk) hw_trigger_select <= 1'b1;
    #1 chk(trig8, 8'h01);
    @(posedge clk) cal_trigger_pin <= 1'b0;
    #1 chk(trig8, 8'h00);
    wr(CTS_ADDR_SOFT_TRIG, 8'h01);
    @(posedge clk) hw_trigger_select <= 1'b0;
    $display("test trigger select done");
    rd(CTS_ADDR_VEC_PORT, 8'h00);
    wr(CTS_ADDR_VEC_EN, 8'h01);
    #1 chk({7'h00, vec_port_open}, 8'h01);
    for (r = 0; r < 673; r++) wr(CTS_ADDR_VEC_PORT, r[7:0] ^ 8'ha5);
    for (r = 0; r < 673; r++) rd(CTS_ADDR_VEC_PORT, r[7:0] ^ 8'ha5);
    wr(CTS_ADDR_VEC_EN, 8'h00);
    rd(CTS_ADDR_VEC_PORT, 8'h00);
    $display("test vector port done");
    wr(CTS_ADDR_LP_CTRL, 8'h01);
    repeat (12) @(posedge clk);
    #1 chk(sleep8, 8'h00);
    @(posedge clk) background_cal_enable <= 1'b1;
    for (r = 0; r < 4; r++)
    begin
      wait_cal(r == 0 ? 19 : 18);
      chk({6'h00, cal_core}, 8'(r % 3));
      if (r < 3)
      begin
        @(posedge clk) cal_done <= 1'b1;
        @(posedge clk) cal_done <= 1'b0;
      end
    end
    @(posedge clk) background_cal_enable <= 1'b0;
    @(posedge clk);
    #1 chk(sleep8, 8'h00);
    $display("test timed schedule done");
    wr(CTS_ADDR_LP_CTRL, 8'h03);
    @(posedge clk) background_cal_enable <= 1'b1;
    repeat (40) @(posedge clk);
    #1 chk(sleep8, 8'h07);
    wr(CTS_ADDR_SOFT_TRIG, 8'h00);
    wait_cal(10);
    @(posedge clk) background_cal_enable <= 1'b0;
    wr(CTS_ADDR_SOFT_TRIG, 8'h01);
    $display("test trigger schedule done");
    // Recommended codes: the settle interval is far too long to finish, so only its start is seen.
    wr(CTS_ADDR_LP_CTRL, 8'h8b);
    @(posedge clk) background_cal_enable <= 1'b1;
    repeat (20) @(posedge clk);
    #1 chk(sleep8, 8'h07);
    wr(CTS_ADDR_SOFT_TRIG, 8'h00);
    repeat (50) @(posedge clk);
    #1 chk(sleep8, 8'h06);
    chk({7'h00, cal_req}, 8'h00);
    @(posedge clk) background_cal_enable <= 1'b0;
    wr(CTS_ADDR_SOFT_TRIG, 8'h01);
    $display("test recommended codes done");
    test_done;
  end
endmodule : test_cts_scheduler
